// ### include/cgscp_pkg.sv
// Shared constants and types for the serial configuration port.
package cgscp_pkg;

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h69;
  localparam int         DATA_W     = 8;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [1:0] LAST_PHASE = 2'h3;

  // ----------------------------------------------------------------
  // Device register map
  // ----------------------------------------------------------------
  localparam int         NUM_REGS      = 256;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] XTAL_CTRL_OFS = 8'h12;
  localparam int         TUNE_SRC_MSB  = 7;
  localparam int         TUNE_SRC_LSB  = 6;
  localparam int         CAP_SRC_BIT   = 5;
  localparam int         GAIN_MSB      = 4;
  localparam int         GAIN_LSB      = 3;
  localparam int         CAP_LOAD_MSB  = 2;
  localparam int         CAP_LOAD_LSB  = 0;
  localparam logic [7:0] CLK_OE_OFS    = 8'h09;
  localparam int         CLKC_OE_BIT   = 5;
  localparam int         CLKA_OE_BIT   = 4;
  localparam int         CLKB_OE_BIT   = 2;

  // ----------------------------------------------------------------
  // Host register map
  // ----------------------------------------------------------------
  localparam logic [2:0] HOST_CTRL_OFS  = 3'h0;
  localparam logic [2:0] HOST_RADDR_OFS = 3'h1;
  localparam logic [2:0] HOST_WDATA_OFS = 3'h2;
  localparam logic [2:0] HOST_STAT_OFS  = 3'h3;
  localparam logic [2:0] HOST_RDATA_OFS = 3'h4;
  localparam int         CTRL_RD_BIT    = 1;
  localparam int         CTRL_WR_BIT    = 0;
  localparam int         STAT_NACK_BIT  = 1;
  localparam int         STAT_BUSY_BIT  = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 50;
  localparam int         SCL_PERIOD_NS = 10000;
  localparam int         QUARTER_INT   = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam logic [5:0] QUARTER_LAST  = 6'(QUARTER_INT - 1);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DIDLE  = 4'h0,
    DADDR  = 4'h1,
    DACKA  = 4'h3,
    DREG   = 4'h2,
    DACKR  = 4'h6,
    DDATA  = 4'h7,
    DACKD  = 4'h5,
    DRDATA = 4'h4,
    DRACK  = 4'hc
  } cgscp_dev_state_t;

  typedef enum logic [1:0] {
    HIDLE  = 2'h0,
    HSTART = 2'h1,
    HBIT   = 2'h3,
    HSTOP  = 2'h2
  } cgscp_host_state_t;

endpackage : cgscp_pkg

// ### include/cgscp_if.sv
// Open-drain two-wire link joining the host and device ends.
`timescale 1ns/1ps
interface cgscp_if;
  logic sclHostOut;
  logic sclHostOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic scl;
  logic sda;

  // Pulled-up wires: low whenever any enabled driver pulls low
  assign scl = !(sclHostOe && !sclHostOut);
  assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

  modport host (
    output sclHostOut,
    output sclHostOe,
    output sdaHostOut,
    output sdaHostOe,
    input  scl,
    input  sda
  );

  modport dev (
    output sdaDevOut,
    output sdaDevOe,
    input  scl,
    input  sda
  );
endinterface : cgscp_if

// ### src/cgscp_dev.sv
// Device end: serial slave and volatile configuration registers.
`timescale 1ns/1ps
module cgscp_dev (
  input  wire logic       clk,
  input  wire logic       nrst,
  cgscp_if.dev            bus,
  input  wire logic [3:0][7:0] tuneAddrCand,
  output logic [7:0]      tuneAddr,
  output logic [1:0]      tuningArrayAddrSource,
  output logic            crystalCapSource,
  output logic [1:0]      crystalDriveGain,
  output logic [2:0]      capLoad,
  output logic [2:0]      clkOutOe,
  output logic            xtalOscEnable,
  output logic            cfgWrite
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic sclMeta;
  logic sclS;
  logic sclPrev;
  logic sdaMeta;
  logic sdaS;
  logic sdaPrev;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclMeta <= 1'b1;
      sclS    <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaS    <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclMeta <= bus.scl;
      sclS    <= sclMeta;
      sclPrev <= sclS;
      sdaMeta <= bus.sda;
      sdaS    <= sdaMeta;
      sdaPrev <= sdaS;
    end
  end

  assign sclRise   = sclS && !sclPrev;
  assign sclFall   = !sclS && sclPrev;
  assign startSeen = sclS && sclPrev && sdaPrev && !sdaS;
  assign stopSeen  = sclS && sclPrev && !sdaPrev && sdaS;

  // ----------------------------------------------------------------
  // Register array
  // ----------------------------------------------------------------
  logic [7:0] regs [cgscp_pkg::NUM_REGS];
  logic [7:0] ptr;
  logic [7:0] shiftReg;
  logic [7:0] txReg;
  logic [3:0] cnt;
  logic       rw;
  logic       masterAck;
  logic       sdaOe;
  logic       wrEn;
  cgscp_pkg::cgscp_dev_state_t state;

  // Byte completes on the falling edge after its eighth bit
  assign wrEn = sclFall && !startSeen && !stopSeen
             && state == cgscp_pkg::DDATA
             && cnt == cgscp_pkg::BYTE_BITS;

  // Reset stands in for power-up: all serial settings return to blank
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < cgscp_pkg::NUM_REGS; i++) begin
        regs[i] <= cgscp_pkg::REG_RESET;
      end
    end else if (wrEn) begin
      regs[ptr] <= shiftReg;
    end
  end

  // ----------------------------------------------------------------
  // Slave protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state     <= cgscp_pkg::DIDLE;
      cnt       <= 4'h0;
      shiftReg  <= 8'h00;
      txReg     <= 8'h00;
      ptr       <= 8'h00;
      rw        <= 1'b0;
      masterAck <= 1'b0;
      sdaOe     <= 1'b0;
    end else if (startSeen) begin
      // Repeated start keeps the pointer for a read-back
      state <= cgscp_pkg::DADDR;
      cnt   <= 4'h0;
      sdaOe <= 1'b0;
    end else if (stopSeen) begin
      state <= cgscp_pkg::DIDLE;
      sdaOe <= 1'b0;
    end else if (sclRise) begin
      case (state)
        cgscp_pkg::DADDR,
        cgscp_pkg::DREG,
        cgscp_pkg::DDATA: begin
          shiftReg <= {shiftReg[6:0], sdaS};
          cnt      <= cnt + 4'h1;
        end
        cgscp_pkg::DRDATA: begin
          cnt <= cnt + 4'h1;
        end
        cgscp_pkg::DRACK: begin
          masterAck <= !sdaS;
        end
        default: begin
        end
      endcase
    end else if (sclFall) begin
      case (state)
        cgscp_pkg::DADDR: begin
          if (cnt == cgscp_pkg::BYTE_BITS) begin
            if (shiftReg[7:1] == cgscp_pkg::SLAVE_ADDR) begin
              state <= cgscp_pkg::DACKA;
              rw    <= shiftReg[0];
              sdaOe <= 1'b1;
            end else begin
              state <= cgscp_pkg::DIDLE;
            end
          end
        end
        cgscp_pkg::DACKA: begin
          cnt <= 4'h0;
          if (rw) begin
            state <= cgscp_pkg::DRDATA;
            txReg <= regs[ptr];
            sdaOe <= !regs[ptr][7];
          end else begin
            state <= cgscp_pkg::DREG;
            sdaOe <= 1'b0;
          end
        end
        cgscp_pkg::DREG: begin
          if (cnt == cgscp_pkg::BYTE_BITS) begin
            ptr   <= shiftReg;
            state <= cgscp_pkg::DACKR;
            sdaOe <= 1'b1;
          end
        end
        cgscp_pkg::DACKR: begin
          state <= cgscp_pkg::DDATA;
          cnt   <= 4'h0;
          sdaOe <= 1'b0;
        end
        cgscp_pkg::DDATA: begin
          if (cnt == cgscp_pkg::BYTE_BITS) begin
            ptr   <= ptr + 8'h01;
            state <= cgscp_pkg::DACKD;
            sdaOe <= 1'b1;
          end
        end
        cgscp_pkg::DACKD: begin
          state <= cgscp_pkg::DDATA;
          cnt   <= 4'h0;
          sdaOe <= 1'b0;
        end
        cgscp_pkg::DRDATA: begin
          if (cnt == cgscp_pkg::BYTE_BITS) begin
            state <= cgscp_pkg::DRACK;
            sdaOe <= 1'b0;
            ptr   <= ptr + 8'h01;
          end else begin
            txReg <= {txReg[6:0], 1'b0};
            sdaOe <= !txReg[6];
          end
        end
        cgscp_pkg::DRACK: begin
          if (masterAck) begin
            state <= cgscp_pkg::DRDATA;
            cnt   <= 4'h0;
            txReg <= regs[ptr];
            sdaOe <= !regs[ptr][7];
          end else begin
            state <= cgscp_pkg::DIDLE;
          end
        end
        default: begin
          state <= cgscp_pkg::DIDLE;
        end
      endcase
    end
  end

  // Device only ever pulls low; no clock stretching
  assign bus.sdaDevOut = 1'b0;
  assign bus.sdaDevOe  = sdaOe;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  logic [7:0] xtalCtrl;
  logic [7:0] clkOeReg;

  assign xtalCtrl = regs[cgscp_pkg::XTAL_CTRL_OFS];
  assign clkOeReg = regs[cgscp_pkg::CLK_OE_OFS];

  assign tuningArrayAddrSource =
    xtalCtrl[cgscp_pkg::TUNE_SRC_MSB:cgscp_pkg::TUNE_SRC_LSB];
  assign crystalCapSource = xtalCtrl[cgscp_pkg::CAP_SRC_BIT];
  assign crystalDriveGain =
    xtalCtrl[cgscp_pkg::GAIN_MSB:cgscp_pkg::GAIN_LSB];
  assign capLoad =
    xtalCtrl[cgscp_pkg::CAP_LOAD_MSB:cgscp_pkg::CAP_LOAD_LSB];

  // Outputs stay tristated until software enables them
  assign clkOutOe = {clkOeReg[cgscp_pkg::CLKC_OE_BIT],
                     clkOeReg[cgscp_pkg::CLKB_OE_BIT],
                     clkOeReg[cgscp_pkg::CLKA_OE_BIT]};

  // Oscillator never stops, even when blank
  assign xtalOscEnable = 1'b1;

  assign cfgWrite = wrEn;

  // ----------------------------------------------------------------
  // Tuning array address source
  // ----------------------------------------------------------------
  // Registered so a source change lands glitch-free
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tuneAddr <= 8'h00;
    end else begin
      tuneAddr <= tuneAddrCand[tuningArrayAddrSource];
    end
  end

endmodule : cgscp_dev

// ### src/cgscp_host.sv
// Host end: two-wire bus master driven through a small register port.
`timescale 1ns/1ps
module cgscp_host (
  input  wire logic       clk,
  input  wire logic       nrst,
  cgscp_if.host           bus,
  input  wire logic [2:0] busAddr,
  input  wire logic [7:0] busWdata,
  input  wire logic       busWr,
  input  wire logic       busRd,
  output logic [7:0]      busRdata
);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [7:0] regAddr;
  logic [7:0] wrData;
  logic [7:0] rdByte;
  logic       busy;
  logic       nack;
  logic       go;
  logic       goRead;

  // Starts ignored while a transfer runs
  assign go     = busWr && busAddr == cgscp_pkg::HOST_CTRL_OFS && !busy;
  assign goRead = busWdata[cgscp_pkg::CTRL_RD_BIT];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      regAddr <= 8'h00;
      wrData  <= 8'h00;
    end else if (busWr && !busy) begin
      if (busAddr == cgscp_pkg::HOST_RADDR_OFS) begin
        regAddr <= busWdata;
      end
      if (busAddr == cgscp_pkg::HOST_WDATA_OFS) begin
        wrData <= busWdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busRdata <= 8'h00;
    end else if (busRd) begin
      case (busAddr)
        cgscp_pkg::HOST_RADDR_OFS: busRdata <= regAddr;
        cgscp_pkg::HOST_WDATA_OFS: busRdata <= wrData;
        cgscp_pkg::HOST_STAT_OFS:  busRdata <= {6'h00, nack, busy};
        cgscp_pkg::HOST_RDATA_OFS: busRdata <= rdByte;
        default:                   busRdata <= 8'h00;
      endcase
    end else begin
      busRdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Data line synchroniser
  // ----------------------------------------------------------------
  logic sdaMeta;
  logic sdaS;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sdaMeta <= 1'b1;
      sdaS    <= 1'b1;
    end else begin
      sdaMeta <= bus.sda;
      sdaS    <= sdaMeta;
    end
  end

  // ----------------------------------------------------------------
  // Bit sequencer
  // ----------------------------------------------------------------
  cgscp_pkg::cgscp_host_state_t state;
  logic [5:0] qCnt;
  logic [1:0] phase;
  logic [3:0] bitK;
  logic [1:0] idx;
  logic       opRead;
  logic [7:0] txByte;
  logic [7:0] rxByte;
  logic       sclOe;
  logic       sdaOe;
  logic       tick;
  logic       lastByte;
  logic       readByte;

  // Byte order: address+write, register, then data or address+read
  function automatic logic [7:0] byteFor(input logic rd,
                                         input logic [1:0] n,
                                         input logic [7:0] ra,
                                         input logic [7:0] wd);
    case (n)
      2'h0:    byteFor = {cgscp_pkg::SLAVE_ADDR, 1'b0};
      2'h1:    byteFor = ra;
      2'h2:    byteFor = rd ? {cgscp_pkg::SLAVE_ADDR, 1'b1} : wd;
      default: byteFor = 8'hff;
    endcase
  endfunction : byteFor

  assign tick     = qCnt == cgscp_pkg::QUARTER_LAST;
  assign readByte = opRead && idx == 2'h3;
  assign lastByte = readByte || (!opRead && idx == 2'h2);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      qCnt <= 6'h00;
    end else if (!busy || tick) begin
      qCnt <= 6'h00;
    end else begin
      qCnt <= qCnt + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state  <= cgscp_pkg::HIDLE;
      phase  <= 2'h0;
      bitK   <= 4'h0;
      idx    <= 2'h0;
      opRead <= 1'b0;
      txByte <= 8'hff;
      rxByte <= 8'h00;
      rdByte <= 8'h00;
      sclOe  <= 1'b0;
      sdaOe  <= 1'b0;
      busy   <= 1'b0;
      nack   <= 1'b0;
    end else if (state == cgscp_pkg::HIDLE) begin
      if (go) begin
        state  <= cgscp_pkg::HSTART;
        phase  <= 2'h0;
        idx    <= 2'h0;
        opRead <= goRead;
        busy   <= 1'b1;
        nack   <= 1'b0;
      end
    end else if (tick) begin
      phase <= phase + 2'h1;
      case (state)
        cgscp_pkg::HSTART: begin
          case (phase)
            2'h0:    sdaOe <= 1'b0;
            2'h1:    sclOe <= 1'b0;
            2'h2:    sdaOe <= 1'b1;
            default: begin
              sclOe  <= 1'b1;
              state  <= cgscp_pkg::HBIT;
              bitK   <= 4'h0;
              txByte <= byteFor(opRead, idx, regAddr, wrData);
            end
          endcase
        end
        cgscp_pkg::HBIT: begin
          case (phase)
            2'h0: sdaOe <= bitK != cgscp_pkg::BYTE_BITS && !txByte[7];
            2'h1: sclOe <= 1'b0;
            2'h2: begin
              if (bitK != cgscp_pkg::BYTE_BITS) begin
                rxByte <= {rxByte[6:0], sdaS};
              end else if (readByte) begin
                rdByte <= rxByte;
              end else begin
                nack <= sdaS;
              end
            end
            default: begin
              sclOe  <= 1'b1;
              txByte <= {txByte[6:0], 1'b1};
              bitK   <= bitK + 4'h1;
              if (bitK == cgscp_pkg::BYTE_BITS) begin
                bitK <= 4'h0;
                idx  <= idx + 2'h1;
                if (nack || lastByte) begin
                  state <= cgscp_pkg::HSTOP;
                end else if (opRead && idx == 2'h1) begin
                  state <= cgscp_pkg::HSTART;
                end else begin
                  txByte <= byteFor(opRead, idx + 2'h1, regAddr, wrData);
                end
              end
            end
          endcase
        end
        cgscp_pkg::HSTOP: begin
          case (phase)
            2'h0:    sdaOe <= 1'b1;
            2'h1:    sclOe <= 1'b0;
            2'h2:    sdaOe <= 1'b0;
            default: begin
              state <= cgscp_pkg::HIDLE;
              busy  <= 1'b0;
            end
          endcase
        end
        default: state <= cgscp_pkg::HIDLE;
      endcase
    end
  end

  assign bus.sclHostOut = 1'b0;
  assign bus.sclHostOe  = sclOe;
  assign bus.sdaHostOut = 1'b0;
  assign bus.sdaHostOe  = sdaOe;

endmodule : cgscp_host

// ### tb/cgscp_properties.sv
// Concurrent checks on the two-wire link between host and device ends.
`timescale 1ns/1ps
module cgscp_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclHostOut,
  input wire logic sclHostOe,
  input wire logic sdaHostOut,
  input wire logic sdaHostOe,
  input wire logic sdaDevOut,
  input wire logic sdaDevOe,
  input wire logic scl,
  input wire logic sda
);
  logic       sclQ;
  logic       sdaQ;
  logic [4:0] bitCnt;
  logic [7:0] addrSr;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    sclQ <= scl;
    sdaQ <= sda;
  end

  // Counts clock rises since the last start; saturates to stay defined
  always_ff @(posedge clk) begin
    if (!nrst || (scl && sclQ && sdaQ && !sda)) begin
      bitCnt <= 5'h00;
    end else if (scl && !sclQ && bitCnt != 5'h1f) begin
      bitCnt <= bitCnt + 5'h01;
    end
  end

  // Address byte frozen after eight bits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addrSr <= 8'h00;
    end else if (scl && !sclQ && bitCnt < 5'h08) begin
      addrSr <= {addrSr[6:0], sda};
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_idleAfterReset;
    $rose(nrst) |-> scl && sda && !sdaDevOe;
  endproperty
  a_idleAfterReset: assert property (p_idleAfterReset)
    else $error("link not idle after reset");

  property p_addrMatch;
    $rose(sdaDevOe) && bitCnt == 5'h08 |->
      addrSr[7:1] == cgscp_pkg::SLAVE_ADDR;
  endproperty
  a_addrMatch: assert property (p_addrMatch)
    else $error("device acked a foreign address");

  property p_ignoreOther;
    bitCnt >= 5'h08 && addrSr[7:1] != cgscp_pkg::SLAVE_ADDR |-> !sdaDevOe;
  endproperty
  a_ignoreOther: assert property (p_ignoreOther)
    else $error("device drove data for a foreign address");

  property p_ackAfterByte;
    $fell(scl) && bitCnt == 5'h08 && addrSr[7:1] == cgscp_pkg::SLAVE_ADDR
      |-> ##[1:8] sdaDevOe;
  endproperty
  a_ackAfterByte: assert property (p_ackAfterByte)
    else $error("no acknowledge to own address");

  property p_noEarlyDrive;
    $rose(sdaDevOe) && bitCnt < 5'h09 |-> bitCnt == 5'h08;
  endproperty
  a_noEarlyDrive: assert property (p_noEarlyDrive)
    else $error("device drove inside the address byte");

  property p_devChangesLow;
    $changed(sdaDevOe) |-> !scl;
  endproperty
  a_devChangesLow: assert property (p_devChangesLow)
    else $error("device changed data while clock high");

  property p_driveHolds;
    $rose(sdaDevOe) |=> sdaDevOe [*8];
  endproperty
  a_driveHolds: assert property (p_driveHolds)
    else $error("device drive too short");

  property p_sclHigh;
    $rose(scl) |-> scl [*8] ##0 !sclHostOut && !sdaHostOut && !sdaDevOut;
  endproperty
  a_sclHigh: assert property (p_sclHigh)
    else $error("clock high phase too short or driven high");

  c_ack: cover property ($rose(sdaDevOe) && bitCnt == 5'h08);
  c_restart: cover property (scl && sclQ && sdaQ && !sda && bitCnt > 5'h08);
  c_reset: cover property ($rose(nrst));
endmodule : cgscp_properties

// ### tb/testbench.sv
// Self-checking bench joining host and device ends over one link.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] key;
    logic [7:0] val;
  } cgscp_note_t;

  logic            clk;
  logic            nrst;
  logic [2:0]      busAddr;
  logic [7:0]      busWdata;
  logic            busWr;
  logic            busRd;
  logic [7:0]      busRdata;
  logic [3:0][7:0] tuneAddrCand;
  logic [7:0]      tuneAddr;
  logic [1:0]      tuneSrc;
  logic            capSrc;
  logic [1:0]      gain;
  logic [2:0]      capLoad;
  logic [2:0]      clkOutOe;
  logic            xtalOscEnable;
  logic            cfgWrite;
  logic            rdQ;
  logic [2:0]      cwQ;
  logic [31:0]     seed;
  logic [7:0]      v;
  logic [7:0]      last;
  int              fail_count;
  int              n_compared;
  cgscp_note_t     rdNotes[$];
  cgscp_note_t     cfgNotes[$];

  cgscp_if link ();

  cgscp_host u_cgscp_host (.clk(clk), .nrst(nrst), .bus(link.host),
    .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
    .busRdata(busRdata));

  cgscp_dev u_cgscp_dev (.clk(clk), .nrst(nrst), .bus(link.dev),
    .tuneAddrCand(tuneAddrCand), .tuneAddr(tuneAddr),
    .tuningArrayAddrSource(tuneSrc), .crystalCapSource(capSrc),
    .crystalDriveGain(gain), .capLoad(capLoad), .clkOutOe(clkOutOe),
    .xtalOscEnable(xtalOscEnable), .cfgWrite(cfgWrite));

  cgscp_properties u_cgscp_properties (.clk(clk), .nrst(nrst),
    .sclHostOut(link.sclHostOut), .sclHostOe(link.sclHostOe),
    .sdaHostOut(link.sdaHostOut), .sdaHostOe(link.sdaHostOe),
    .sdaDevOut(link.sdaDevOut), .sdaDevOe(link.sdaDevOe),
    .scl(link.scl), .sda(link.sda));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic chk(input string name, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // One idle cycle after each strobe keeps drivers single per step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    busAddr  <= a;
    busWdata <= d;
    busWr    <= 1'b1;
    @(posedge clk);
    busWr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [2:0] a, input cgscp_note_t n,
                    output logic [7:0] q);
    busAddr <= a;
    busRd   <= 1'b1;
    @(posedge clk);
    busRd <= 1'b0;
    rdNotes.push_back(n);
    // Read data stands only until the next edge; take it mid-cycle
    @(negedge clk);
    q = busRdata;
    @(posedge clk);
  endtask : rd

  task automatic waitIdle();
    logic [7:0] s;
    int         k;
    s = 8'h01;
    k = 0;
    while (s[cgscp_pkg::STAT_BUSY_BIT] !== 1'b0 && k < 2000) begin
      repeat (8) @(posedge clk);
      rd(cgscp_pkg::HOST_STAT_OFS, '0, s);
      k++;
    end
    chk("busy", 8'h00, {7'h00, s[cgscp_pkg::STAT_BUSY_BIT]});
    chk("nack", 8'h00, {7'h00, s[cgscp_pkg::STAT_NACK_BIT]});
  endtask : waitIdle

  task automatic put(input logic [7:0] ofs, input logic [7:0] val);
    wr(cgscp_pkg::HOST_RADDR_OFS, ofs);
    wr(cgscp_pkg::HOST_WDATA_OFS, val);
    cfgNotes.push_back('{ofs, val});
    wr(cgscp_pkg::HOST_CTRL_OFS, 8'h01);
  endtask : put

  task automatic get(input logic [7:0] ofs, input logic [7:0] val);
    wr(cgscp_pkg::HOST_RADDR_OFS, ofs);
    wr(cgscp_pkg::HOST_CTRL_OFS, 8'h02);
    waitIdle();
    rd(cgscp_pkg::HOST_RDATA_OFS, '{8'hff, val}, v);
  endtask : get

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  // Falling edge: registered outputs have settled, no race with launch
  always @(negedge clk) begin
    cgscp_note_t n;
    rdQ <= busRd;
    cwQ <= {cwQ[1:0], cfgWrite};
    if (rdQ === 1'b1 && rdNotes.size() > 0) begin
      n = rdNotes.pop_front();
      if (n.key !== 8'h00) begin
        chk("busRdata", n.val, busRdata & n.key);
      end
    end
    if (cwQ[2] === 1'b1) begin
      n = cfgNotes.pop_front();
      if (n.key === cgscp_pkg::XTAL_CTRL_OFS) begin
        chk("xtalFields", n.val, {tuneSrc, capSrc, gain, capLoad});
        chk("gain", {6'h00, n.val[4:3]}, {6'h00, gain});
        chk("tuneAddr", tuneAddrCand[n.val[7:6]], tuneAddr);
      end else begin
        chk("clkOutOe", {5'h00, n.val[5], n.val[2], n.val[4]},
            {5'h00, clkOutOe});
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Longest run is about 60000 cycles of serial traffic
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    final_report();
  end

  initial begin
    nrst = 1'b0;
    busAddr = 3'h0;
    busWdata = 8'h00;
    busWr = 1'b0;
    busRd = 1'b0;
    fail_count = 0;
    n_compared = 0;
    seed = 32'h0000ef00;
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      tuneAddrCand[i] = seed[7:0];
    end
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("blankFields", 8'h00, {tuneSrc, capSrc, gain, capLoad});
    chk("blankOe", 8'h08, {4'h0, xtalOscEnable, clkOutOe});
    $display("test blank done");
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      last = {i[1:0], seed[5:0]};
      put(cgscp_pkg::XTAL_CTRL_OFS, last);
      waitIdle();
    end
    get(cgscp_pkg::XTAL_CTRL_OFS, last);
    $display("test tuning sources done");
    put(cgscp_pkg::CLK_OE_OFS, 8'h14);
    waitIdle();
    $display("test output enables done");
    // Data written while busy must not reach the wire
    put(cgscp_pkg::XTAL_CTRL_OFS, ~last);
    wr(cgscp_pkg::HOST_WDATA_OFS, last);
    waitIdle();
    $display("test busy refusal done");
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("lostFields", 8'h00, {tuneSrc, capSrc, gain, capLoad});
    get(cgscp_pkg::XTAL_CTRL_OFS, 8'h00);
    put(cgscp_pkg::XTAL_CTRL_OFS, last);
    waitIdle();
    $display("test reset loss done");
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : testbench
